// ===== common/pbr_pkg.sv
// Constants shared by the parity checking bus register and its pipeline.
// Assumes a single clock domain and a plain strobed register port.
package pbr_pkg;

    // Data path geometry
    localparam int DATA_W     = 12;
    localparam int PAR_W      = 10;
    localparam int HOLD_W     = 8;
    localparam int STROBE_BIT = 10;

    // Parity pipeline fill: sum, delayed result, error flag
    localparam logic [1:0] PIPE_FULL = 2'h3;
    localparam logic [1:0] PIPE_STEP = 2'h1;
    localparam logic [1:0] PIPE_RST  = 2'h0;

    // Register port
    localparam int ADDR_W = 4;
    localparam int REG_W  = 32;

    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_MASK   = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_DATA   = 4'h8;

    // Status and mask layout
    localparam int STATUS_W = 2;
    localparam int ST_ERR   = 0;
    localparam int ST_VALID = 1;

    localparam logic [STATUS_W-1:0] STATUS_RST = 2'h0;
    localparam logic [STATUS_W-1:0] MASK_RST   = 2'h0;
    localparam logic [STATUS_W-1:0] STICKY_MSK = 2'h1;

endpackage

// ===== logic/pbr_parity_pipe.sv
// Two-stage parity pipeline: word sum, then sum folded with late parity.
// Assumes parity arrives one clock after its word; no reset by design.
`timescale 1ns/1ps

module pbr_parity_pipe #(
    parameter int PAR_W = pbr_pkg::PAR_W
) (
    input  wire logic             clk_sys,
    input  wire logic [PAR_W-1:0] word_bits,
    input  wire logic             parity_bit_in,
    output logic                  word_sum_ff,
    output logic                  result_ff
);

    logic nxt_word_sum;
    logic nxt_result;

    assign nxt_word_sum = ^word_bits;
    assign nxt_result   = word_sum_ff ^ parity_bit_in;

    // Runs every edge, whatever the capture enable does
    always_ff @(posedge clk_sys)
    begin
        word_sum_ff <= nxt_word_sum;
        result_ff   <= nxt_result;
    end

endmodule

// ===== logic/pbr_top.sv
// Parity checking 12-bit bus register with dual outputs and cascade pin.
// Assumes all pin-side inputs come from logic on clk_sys.
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps

module pbr_top #(
    parameter int DATA_W = pbr_pkg::DATA_W
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rstn,
    input  wire logic [DATA_W-1:0]          data_in,
    input  wire logic                       path_select_buffer,
    input  wire logic                       capture_enable_n,
    input  wire logic                       output_enable_n,
    input  wire logic                       parity_bit_in,
    input  wire logic                       parity_pin_drive_enable_n,
    input  wire logic                       parity_select_or_cascade_i,
    output logic                            parity_select_or_cascade_o,
    output logic                            parity_select_or_cascade_oe,
    output logic [DATA_W-1:0]               data_out_copy1,
    output logic [DATA_W-1:0]               data_out_copy2,
    output logic                            data_out_oe,
    output logic                            parity_error_n_o,
    output logic                            parity_error_n_oe,
    input  wire logic [pbr_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [pbr_pkg::REG_W-1:0]  reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic [pbr_pkg::REG_W-1:0]       reg_rdata,
    output logic                            irq
);

    localparam int HOLD_W   = pbr_pkg::HOLD_W;
    localparam int PAR_W    = pbr_pkg::PAR_W;
    localparam int STATUS_W = pbr_pkg::STATUS_W;

    // ------------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] stored_ff;
    logic [DATA_W-1:0] nxt_stored;
    logic              bit11_and_error_strobe_n;
    logic              capture_low_bits;

    assign bit11_and_error_strobe_n = data_in[pbr_pkg::STROBE_BIT];

    // Buffer mode refreshes every bit; register mode may hold bits 1-8
    assign capture_low_bits = path_select_buffer | ~capture_enable_n;

    generate
        for (genvar i = 0; i < DATA_W; i++)
        begin : g_bit
            if (i < HOLD_W)
            begin : g_hold
                assign nxt_stored[i] = capture_low_bits ? data_in[i]
                                                        : stored_ff[i];
            end
            else
            begin : g_free
                assign nxt_stored[i] = data_in[i];
            end
        end
    endgenerate

    // Data registers carry no reset
    always_ff @(posedge clk_sys)
    begin
        stored_ff <= nxt_stored;
    end

    // Two separate copies of each bit
    always_ff @(posedge clk_sys)
    begin
        data_out_copy1 <= nxt_stored;
        data_out_copy2 <= nxt_stored;
    end

    // ------------------------------------------------------------------
    // Parity pipeline
    // ------------------------------------------------------------------
    logic word_sum_ff;
    logic result_ff;

    pbr_parity_pipe #(
        .PAR_W         (PAR_W)
    ) u_parity_pipe (
        .clk_sys       (clk_sys),
        .word_bits     (data_in[PAR_W-1:0]),
        .parity_bit_in (parity_bit_in),
        .word_sum_ff   (word_sum_ff),
        .result_ff     (result_ff)
    );

    // Pipeline fill count, so early flags are kept out of status and irq
    logic [1:0] fill_ff;
    logic [1:0] nxt_fill;
    logic       pipe_valid;

    assign pipe_valid = (fill_ff == pbr_pkg::PIPE_FULL);
    assign nxt_fill   = pipe_valid ? fill_ff
                                   : fill_ff + pbr_pkg::PIPE_STEP;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            fill_ff <= pbr_pkg::PIPE_RST;
        else
            fill_ff <= nxt_fill;
    end

    // Error flag: pin acts as parity select or as cascade partial sum
    logic pin_is_input;
    logic mismatch;
    logic err_n_ff;
    logic nxt_err_n;

    assign pin_is_input = parity_pin_drive_enable_n;
    assign mismatch     = result_ff ^ parity_select_or_cascade_i;
    assign nxt_err_n    = bit11_and_error_strobe_n | ~mismatch;

    always_ff @(posedge clk_sys)
    begin
        err_n_ff <= nxt_err_n;
    end

    // ------------------------------------------------------------------
    // Output drivers
    // ------------------------------------------------------------------
    logic nxt_err_drive;
    logic nxt_pin_drive;

    assign nxt_err_drive = ~output_enable_n & ~nxt_err_n;
    assign nxt_pin_drive = ~parity_pin_drive_enable_n;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            data_out_oe                 <= 1'b0;
            parity_error_n_oe           <= 1'b0;
            parity_error_n_o            <= 1'b0;
            parity_select_or_cascade_oe <= 1'b0;
        end
        else
        begin
            data_out_oe                 <= ~output_enable_n;
            parity_error_n_oe           <= nxt_err_drive;
            parity_error_n_o            <= 1'b0;
            parity_select_or_cascade_oe <= nxt_pin_drive;
        end
    end

    // Cascade sum for the second device
    always_ff @(posedge clk_sys)
    begin
        parity_select_or_cascade_o <= result_ff;
    end

    // ------------------------------------------------------------------
    // Register port and interrupt
    // ------------------------------------------------------------------
    logic [STATUS_W-1:0]      status_ff;
    logic [STATUS_W-1:0]      mask_ff;
    logic [STATUS_W-1:0]      nxt_status;
    logic [STATUS_W-1:0]      status_view;
    logic [STATUS_W-1:0]      event_set;
    logic                     sel_status;
    logic                     sel_mask;
    logic                     sel_data;
    logic                     status_rd;
    logic [pbr_pkg::REG_W-1:0] nxt_rdata;
    logic                     nxt_irq;
    logic [STATUS_W-1:0]      nxt_mask;

    assign sel_status = (reg_addr == pbr_pkg::ADDR_STATUS);
    assign sel_mask   = (reg_addr == pbr_pkg::ADDR_MASK);
    assign sel_data   = (reg_addr == pbr_pkg::ADDR_DATA);
    assign status_rd  = reg_rd & sel_status;

    // Flags counted only once the pipeline holds valid data
    assign event_set = {1'b0, pipe_valid & ~err_n_ff};

    // Set wins over read-clear
    assign nxt_status = (status_rd ? (status_ff & ~pbr_pkg::STICKY_MSK)
                                   : status_ff) | event_set;

    assign status_view = {pipe_valid, status_ff[pbr_pkg::ST_ERR]};

    assign nxt_rdata =
        !reg_rd    ? '0 :
        sel_status ? pbr_pkg::REG_W'(status_view) :
        sel_mask   ? pbr_pkg::REG_W'(mask_ff) :
        sel_data   ? pbr_pkg::REG_W'(stored_ff) :
                     '0;

    // Mask write reaches the interrupt in the same cycle as the mask
    assign nxt_mask = (reg_wr && sel_mask) ? reg_wdata[STATUS_W-1:0]
                                           : mask_ff;

    assign nxt_irq = |(nxt_status & nxt_mask & pbr_pkg::STICKY_MSK);

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            status_ff <= pbr_pkg::STATUS_RST;
            mask_ff   <= pbr_pkg::MASK_RST;
            reg_rdata <= '0;
            irq       <= 1'b0;
        end
        else
        begin
            status_ff <= nxt_status;
            mask_ff   <= nxt_mask;
            reg_rdata <= nxt_rdata;
            irq       <= nxt_irq;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic parity_of_word;

    assign parity_of_word = ^data_in[PAR_W-1:0];

    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence s_word_then_parity;
        1'b1 ##1 1'b1 ##1 pipe_valid;
    endsequence

    sequence s_register_hold;
        !path_select_buffer && capture_enable_n;
    endsequence

    a_copies_match:
    assert property (data_out_copy1 == data_out_copy2)
    else $error("Output copies differ");

    a_capture_all:
    assert property (!path_select_buffer && !capture_enable_n
                     |=> stored_ff == $past(data_in))
    else $error("Register mode did not store all bits");

    a_hold_low_bits:
    assert property (s_register_hold
                     |=> stored_ff[HOLD_W-1:0]
                         == $past(stored_ff[HOLD_W-1:0])
                         && stored_ff[DATA_W-1:HOLD_W]
                         == $past(data_in[DATA_W-1:HOLD_W]))
    else $error("Low bits changed with capture disabled");

    a_buffer_pass:
    assert property (path_select_buffer
                     |=> data_out_copy1 == $past(data_in))
    else $error("Buffer mode did not pass data");

    a_error_timing:
    assert property (s_word_then_parity
                     |=> err_n_ff == ($past(bit11_and_error_strobe_n)
                         | ~($past(parity_of_word, 3)
                         ^ $past(parity_bit_in, 2)
                         ^ $past(parity_select_or_cascade_i))))
    else $error("Error flag wrong two clocks after word");

    a_strobe_release:
    assert property (bit11_and_error_strobe_n
                     |=> err_n_ff && !parity_error_n_oe)
    else $error("Error flag not released by bit 11");

    a_outputs_float:
    assert property (output_enable_n
                     |=> !data_out_oe && !parity_error_n_oe)
    else $error("Drivers active with output enable high");

    a_cascade_drive:
    assert property (!parity_pin_drive_enable_n
                     |=> parity_select_or_cascade_oe
                         && parity_select_or_cascade_o
                         == $past(result_ff))
    else $error("Cascade pin not driven with partial sum");

    a_cascade_float:
    assert property (pin_is_input |=> !parity_select_or_cascade_oe)
    else $error("Cascade pin driven while input");

    a_error_sticky:
    assert property (pipe_valid && !err_n_ff
                     |=> status_ff[pbr_pkg::ST_ERR])
    else $error("Parity error not recorded");

    a_no_early_event:
    assert property (!pipe_valid |=> !$rose(status_ff[pbr_pkg::ST_ERR]))
    else $error("Event recorded before pipeline filled");

    a_err_driver:
    assert property (pipe_valid && !output_enable_n
                     |=> parity_error_n_oe == !err_n_ff)
    else $error("Error driver does not follow error flag");

    a_keep_floating:
    assert property (output_enable_n
                     |=> stored_ff[DATA_W-1:HOLD_W]
                         == $past(data_in[DATA_W-1:HOLD_W]))
    else $error("Storage stopped while outputs float");

    a_parity_pair:
    assert property (pipe_valid
                     |-> result_ff == ($past(parity_of_word, 2)
                                       ^ $past(parity_bit_in)))
    else $error("Parity bit not paired with previous word");

    a_cascade_sum:
    assert property (pipe_valid && !parity_pin_drive_enable_n
                     |=> parity_select_or_cascade_o
                         == ($past(parity_of_word, 3)
                             ^ $past(parity_bit_in, 2)))
    else $error("Cascade pin does not carry the partial sum");

    a_irq_level:
    assert property (irq == (status_ff[pbr_pkg::ST_ERR]
                             && mask_ff[pbr_pkg::ST_ERR]))
    else $error("Interrupt does not follow unmasked status");

    a_read_idle:
    assert property (!reg_rd |=> reg_rdata == '0)
    else $error("Read data shown without a read");

endmodule

// ===== tb/pbr_bus_model.sv
// Bus-side partner: presents words, then their parity one edge later.
// Assumes the bench changes word and corrupt just after a rising edge.
`timescale 1ns/1ps

module pbr_bus_model (
    input  wire logic                       clk_sys,
    input  wire logic [pbr_pkg::DATA_W-1:0] word,
    input  wire logic                       corrupt,
    input  wire logic                       odd_sel,
    input  wire logic                       cascade_en,
    input  wire logic                       pin_o,
    input  wire logic                       pin_oe,
    output logic [pbr_pkg::DATA_W-1:0]      data_in,
    output logic                            parity_bit_in,
    output logic                            parity_pin_drive_enable_n,
    output logic                            parity_select_or_cascade_i
);
    assign data_in = word;
    // Lone checker keeps the pin an input
    assign parity_pin_drive_enable_n = ~cascade_en;
    // Wire level: device drive wins, else the select level
    assign parity_select_or_cascade_i = pin_oe ? pin_o : odd_sel;

    // Parity of the word sampled at this edge, shown for the next one
    always_ff @(posedge clk_sys)
    begin
        parity_bit_in <= (^word[9:0]) ^ odd_sel ^ corrupt;
    end
endmodule

// ===== tb/parity_checking_bus_register_bench.sv
// Self-checking bench for the parity checking bus register.
// Assumes the bus partner model and the register port contract.
`timescale 1ns/1ps

module parity_checking_bus_register_bench;
    logic        clk_sys;
    logic        rstn;
    logic [11:0] word;
    logic [11:0] data_in;
    logic        corrupt;
    logic        odd_sel;
    logic        cascade_en;
    logic        path_sel;
    logic        cen_n;
    logic        oe_n;
    logic        par_in;
    logic        drv_n;
    logic        pin_i;
    logic        pin_o;
    logic        pin_oe;
    logic [11:0] copy1;
    logic [11:0] copy2;
    logic        dout_oe;
    logic        err_o;
    logic        err_oe;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        irq;
    logic [31:0] rv;
    int          bad_count;
    int          checks;

    pbr_bus_model partner (
        .clk_sys(clk_sys), .word(word), .corrupt(corrupt),
        .odd_sel(odd_sel), .cascade_en(cascade_en), .pin_o(pin_o),
        .pin_oe(pin_oe), .data_in(data_in), .parity_bit_in(par_in),
        .parity_pin_drive_enable_n(drv_n),
        .parity_select_or_cascade_i(pin_i)
    );

    pbr_top DUT (
        .clk_sys(clk_sys), .rstn(rstn), .data_in(data_in),
        .path_select_buffer(path_sel), .capture_enable_n(cen_n),
        .output_enable_n(oe_n), .parity_bit_in(par_in),
        .parity_pin_drive_enable_n(drv_n),
        .parity_select_or_cascade_i(pin_i),
        .parity_select_or_cascade_o(pin_o),
        .parity_select_or_cascade_oe(pin_oe),
        .data_out_copy1(copy1), .data_out_copy2(copy2),
        .data_out_oe(dout_oe), .parity_error_n_o(err_o),
        .parity_error_n_oe(err_oe), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic final_report;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic put(input logic [11:0] w, input logic c);
        @(posedge clk_sys);
        word    <= w;
        corrupt <= c;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Word with optional fault, filler, then the strobe word
    task automatic par(input logic c, input logic strobe, input logic exp);
        put(12'h0a5, c);
        put(12'h003, 1'b0);
        put({1'b0, strobe, 10'h001}, 1'b0);
        tick();
        if (!cascade_en)
            cmp(err_oe, exp);
        cmp(err_o, 1'b0);
        cmp(pin_o, odd_sel ^ c);
    endtask

    task automatic s_buffer;
        logic [11:0] w [3] = '{12'h5a3, 12'hfff, 12'h000};
        foreach (w[i])
        begin
            put(w[i], 1'b0);
            tick();
            cmp(copy1, w[i]);
            cmp(copy2, w[i]);
        end
        cmp(dout_oe, 1'b1);
    endtask

    task automatic s_register;
        @(posedge clk_sys);
        path_sel <= 1'b0;
        put(12'h0ff, 1'b0);
        tick();
        cmp(copy1, 12'h0ff);
        @(posedge clk_sys);
        cen_n <= 1'b1;
        put(12'h300, 1'b0);
        tick();
        cmp(copy2, 12'h3ff);
        tick();
        cmp(copy1, 12'h3ff);
        @(posedge clk_sys);
        cen_n    <= 1'b0;
        path_sel <= 1'b1;
    endtask

    task automatic s_parity;
        for (int o = 0; o < 2; o++)
        begin
            @(posedge clk_sys);
            odd_sel <= o[0];
            par(1'b0, 1'b0, 1'b0);
            par(1'b1, 1'b0, 1'b1);
        end
        par(1'b1, 1'b1, 1'b0);
        @(posedge clk_sys);
        odd_sel <= 1'b0;
    endtask

    task automatic s_irq;
        repeat (3) tick();
        rd(pbr_pkg::ADDR_STATUS, rv);
        wr(pbr_pkg::ADDR_MASK, 32'h1);
        rd(pbr_pkg::ADDR_MASK, rv);
        cmp(rv, 32'h1);
        par(1'b1, 1'b0, 1'b1);
        tick();
        cmp(irq, 1'b1);
        rd(pbr_pkg::ADDR_STATUS, rv);
        cmp(rv, 32'h3);
        tick();
        cmp(irq, 1'b0);
        rd(pbr_pkg::ADDR_STATUS, rv);
        cmp(rv, 32'h2);
        wr(pbr_pkg::ADDR_MASK, 32'h0);
        par(1'b1, 1'b0, 1'b1);
        repeat (4) tick();
        cmp(irq, 1'b0);
        rd(pbr_pkg::ADDR_STATUS, rv);
        cmp(rv, 32'h3);
    endtask

    task automatic s_oe_cascade;
        @(posedge clk_sys);
        oe_n <= 1'b1;
        put(12'h123, 1'b0);
        tick();
        cmp(dout_oe, 1'b0);
        wr(pbr_pkg::ADDR_DATA, 32'hfff);
        rd(pbr_pkg::ADDR_DATA, rv);
        cmp(rv, 32'h123);
        par(1'b1, 1'b0, 1'b0);
        @(posedge clk_sys);
        oe_n       <= 1'b0;
        cascade_en <= 1'b1;
        par(1'b1, 1'b0, 1'b0);
        cmp(pin_oe, 1'b1);
        @(posedge clk_sys);
        cascade_en <= 1'b0;
        repeat (2) tick();
        cmp(pin_oe, 1'b0);
    endtask

    initial
    begin
        #200us;
        bad_count++;
        final_report();
    end

    initial
    begin
        {rstn, word, corrupt, odd_sel, cascade_en, cen_n, oe_n} = '0;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        path_sel  = 1'b1;
        bad_count = 0;
        checks    = 0;
        repeat (3) @(posedge clk_sys);
        cmp({dout_oe, err_oe, irq, pin_oe}, 4'h0);
        rstn <= 1'b1;
        repeat (4) tick();
        rd(pbr_pkg::ADDR_STATUS, rv);
        cmp(rv, 32'h2);
        rd(4'hc, rv);
        cmp(rv, 32'h0);
        s_buffer();
        s_register();
        s_parity();
        s_irq();
        s_oe_cascade();
        final_report();
    end
endmodule
